// [rtl/fep_line_coding.sv]
// Contract
// - Each data nibble maps to its fixed 5-bit code group on transmit and back on receive.
// - IDLE 11111 fills the line between streams and carries no data nibble on receive.
// - A stream starts with J 11000 directly followed by K 10001, both standing for nibble 0101.
// - A stream ends with T 01101 directly followed by R 00111, neither carrying a nibble.
// - H 00100 is the transmit error symbol and carries no nibble.
// - The ten unassigned code groups are recognised as invalid and flag the reception faulty.
// - Transmit bits are scrambled and receive bits are recovered by a modulo-2 key stream.
// - The scrambler seed comes from the channel management address.
// - The descrambler syncs its key on received IDLE and then holds that key locked.
// - The line encoder gives three levels, a 1 changes level, a 0 holds, and peaks alternate.
// - The receive path turns the three-level stream back into NRZ before descrambling.
// - The strap picks frame start detection: 0 needs J then K, 1 (default) needs only J.
`timescale 1ns/10ps
`default_nettype none
`include "fep_defs.svh"

module fep_line_coding import fep_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_tx_en,
  input wire logic i_tx_er,
  input wire logic [3:0] i_txd,
  input wire logic [4:0] i_phy_addr,
  input wire logic i_frame_start_detect_strap,
  input wire logic [1:0] i_rx_level,
  output logic o_tx_take,
  output logic [1:0] o_tx_level,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic [3:0] o_rxd,
  output logic o_rx_sof,
  output logic o_desc_locked
);

  // Strap and address capture after reset release
  logic strap_s1, strap_s2, frame_start_detect_strap;
  logic [4:0] addr_s1, addr_s2;
  logic [1:0] strap_cnt;
  logic next_strap_s1, next_strap_s2, next_strap;
  logic [4:0] next_addr_s1, next_addr_s2;
  logic [1:0] next_strap_cnt;
  logic seed_load;

  always_comb begin
    next_strap_s1 = i_frame_start_detect_strap;
    next_strap_s2 = strap_s1;
    next_addr_s1 = i_phy_addr;
    next_addr_s2 = addr_s1;
    seed_load = (strap_cnt == `FEP_STRAP_CAP);
    next_strap_cnt = (strap_cnt == `FEP_STRAP_DONE) ? strap_cnt : strap_cnt + 2'h1;
    next_strap = seed_load ? strap_s2 : frame_start_detect_strap;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_s1 <= `FEP_STRAP_DEF;
      strap_s2 <= `FEP_STRAP_DEF;
      frame_start_detect_strap <= `FEP_STRAP_DEF;
      addr_s1 <= 5'h00;
      addr_s2 <= 5'h00;
      strap_cnt <= 2'h0;
    end else begin
      strap_s1 <= next_strap_s1;
      strap_s2 <= next_strap_s2;
      frame_start_detect_strap <= next_strap;
      addr_s1 <= next_addr_s1;
      addr_s2 <= next_addr_s2;
      strap_cnt <= next_strap_cnt;
    end
  end

  // Transmit framing and 4B/5B encoding
  fep_tx_st_e tx_st, next_tx_st;
  logic [2:0] tx_cnt, next_tx_cnt;
  logic [4:0] tx_grp, next_tx_grp;
  logic next_tx_take;
  logic tx_key, tx_plain, tx_line_bit;

  always_comb begin
    next_tx_cnt = o_tx_take ? 3'h0 : tx_cnt + 3'h1;
    next_tx_take = (tx_cnt == `FEP_GRP_LAST - 3'h1);
    next_tx_st = tx_st;
    next_tx_grp = tx_grp;
    if (o_tx_take) begin
      case (tx_st)
        TX_IDLE, TX_R: begin
          if (i_tx_en) begin
            next_tx_st = TX_J;
            next_tx_grp = `FEP_CG_J;
          end else begin
            next_tx_st = TX_IDLE;
            next_tx_grp = `FEP_CG_IDLE;
          end
        end
        TX_J: begin
          next_tx_st = TX_K;
          next_tx_grp = `FEP_CG_K;
        end
        TX_K, TX_DATA: begin
          if (i_tx_en) begin
            next_tx_st = TX_DATA;
            next_tx_grp = i_tx_er ? `FEP_CG_H : fep_enc(i_txd);
          end else begin
            next_tx_st = TX_T;
            next_tx_grp = `FEP_CG_T;
          end
        end
        TX_T: begin
          next_tx_st = TX_R;
          next_tx_grp = `FEP_CG_R;
        end
        default: begin
          next_tx_st = TX_IDLE;
          next_tx_grp = `FEP_CG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_st <= TX_IDLE;
      tx_cnt <= 3'h0;
      tx_grp <= `FEP_CG_IDLE;
      o_tx_take <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      tx_cnt <= next_tx_cnt;
      tx_grp <= next_tx_grp;
      o_tx_take <= next_tx_take;
    end
  end

  // Code group goes out most significant bit first
  assign tx_plain = tx_grp[3'(`FEP_GRP_LAST - tx_cnt)];
  assign tx_line_bit = tx_plain ^ tx_key;

  logic [`FEP_LFSR_W-1:0] scr_seed;
  assign scr_seed = {addr_s2, `FEP_SEED_FILL};

  fep_scr_lfsr u_tx_lfsr (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_load(seed_load),
    .i_seed(scr_seed),
    .i_sync(1'b0),
    .i_sync_bit(tx_plain),
    .o_key(tx_key)
  );

  // Three-level line encoder
  logic tx_last_pos, next_tx_last_pos;
  logic [1:0] next_tx_level;

  always_comb begin
    next_tx_level = o_tx_level;
    next_tx_last_pos = tx_last_pos;
    if (tx_line_bit) begin
      if (o_tx_level == `FEP_LVL_ZERO) begin
        next_tx_level = tx_last_pos ? `FEP_LVL_NEG : `FEP_LVL_POS;
        next_tx_last_pos = !tx_last_pos;
      end else begin
        next_tx_level = `FEP_LVL_ZERO;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx_level <= `FEP_LVL_ZERO;
      tx_last_pos <= 1'b0;
    end else begin
      o_tx_level <= next_tx_level;
      tx_last_pos <= next_tx_last_pos;
    end
  end

  // Receive: line decode, descramble, align, 5B/4B decode
  logic [1:0] rx_prev_level;
  logic rx_nrz, rx_key, rx_plain, rx_match;
  logic [5:0] lock_cnt, next_lock_cnt;
  logic next_locked;
  logic [9:0] rx_sh, next_rx_sh;
  logic [2:0] rx_cnt, next_rx_cnt;
  logic in_frame, next_in_frame;
  logic next_sof;
  fep_rx_s rx_out, next_rx_out;
  fep_dec_s rx_dec;
  logic rx_hit;

  assign rx_nrz = (i_rx_level != rx_prev_level);
  assign rx_plain = rx_nrz ^ rx_key;
  // IDLE plain text is all ones, so the expected key is the inverted cipher bit
  assign rx_match = (rx_key == !rx_nrz);

  fep_scr_lfsr u_rx_lfsr (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_load(1'b0),
    .i_seed(scr_seed),
    .i_sync(!o_desc_locked),
    .i_sync_bit(!rx_nrz),
    .o_key(rx_key)
  );

  always_comb begin
    next_lock_cnt = lock_cnt;
    next_locked = o_desc_locked;
    if (!o_desc_locked) begin
      next_lock_cnt = rx_match ? lock_cnt + 6'h01 : 6'h00;
      next_locked = rx_match && (lock_cnt == `FEP_LOCK_RUN - 6'h01);
    end
    next_rx_sh = {rx_sh[8:0], rx_plain};
    rx_dec = fep_dec(next_rx_sh[4:0]);
    rx_hit = frame_start_detect_strap ?
             (next_rx_sh[5:0] == {1'b1, `FEP_CG_J}) :
             (next_rx_sh == {`FEP_CG_J, `FEP_CG_K});
    next_rx_cnt = rx_cnt + 3'h1;
    next_in_frame = in_frame;
    next_sof = 1'b0;
    next_rx_out = rx_out;
    if (!in_frame) begin
      next_rx_out = '0;
      if (o_desc_locked && rx_hit) begin
        next_in_frame = 1'b1;
        next_rx_cnt = 3'h0;
        next_sof = 1'b1;
        next_rx_out = '{dv: 1'b1, er: 1'b0, nib: `FEP_NIB_JK};
      end
    end else if (rx_cnt == `FEP_GRP_LAST) begin
      next_rx_cnt = 3'h0;
      if (rx_dec.data) begin
        next_rx_out = '{dv: 1'b1, er: 1'b0, nib: rx_dec.nib};
      end else if (next_rx_sh[4:0] == `FEP_CG_J || next_rx_sh[4:0] == `FEP_CG_K) begin
        next_rx_out = '{dv: 1'b1, er: 1'b0, nib: `FEP_NIB_JK};
      end else if (next_rx_sh[4:0] == `FEP_CG_T || next_rx_sh[4:0] == `FEP_CG_IDLE) begin
        next_in_frame = 1'b0;
        next_rx_out = '0;
      end else begin
        // H, a stray R or an unassigned group marks the frame faulty
        next_rx_out = '{dv: 1'b1, er: 1'b1, nib: 4'h0};
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_prev_level <= `FEP_LVL_ZERO;
      lock_cnt <= 6'h00;
      o_desc_locked <= 1'b0;
      rx_sh <= 10'h000;
      rx_cnt <= 3'h0;
      in_frame <= 1'b0;
      o_rx_sof <= 1'b0;
      rx_out <= '0;
    end else begin
      rx_prev_level <= i_rx_level;
      lock_cnt <= next_lock_cnt;
      o_desc_locked <= next_locked;
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      in_frame <= next_in_frame;
      o_rx_sof <= next_sof;
      rx_out <= next_rx_out;
    end
  end

  assign o_rx_dv = rx_out.dv;
  assign o_rx_er = rx_out.er;
  assign o_rxd = rx_out.nib;

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_start_pair;
    (tx_grp == `FEP_CG_J) ##5 (tx_grp == `FEP_CG_K);
  endsequence

  sequence s_end_pair;
    (tx_grp == `FEP_CG_T) ##5 (tx_grp == `FEP_CG_R) ##5 (tx_grp == `FEP_CG_IDLE);
  endsequence

  property p_tx_start;
    (o_tx_take && (tx_st == TX_IDLE || tx_st == TX_R) && i_tx_en) |=> s_start_pair;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start delimiter pair missing");

  property p_tx_end;
    (o_tx_take && tx_st == TX_DATA && !i_tx_en) |=> s_end_pair;
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("end delimiter pair missing");

  property p_tx_data;
    (o_tx_take && (tx_st == TX_K || tx_st == TX_DATA) && i_tx_en && !i_tx_er)
      |=> (tx_grp == fep_enc($past(i_txd)));
  endproperty
  a_tx_data: assert property (p_tx_data) else $error("data code group wrong");

  property p_tx_err;
    (o_tx_take && tx_st == TX_DATA && i_tx_en && i_tx_er) |=> (tx_grp == `FEP_CG_H);
  endproperty
  a_tx_err: assert property (p_tx_err) else $error("error symbol not sent");

  property p_mlt_change;
    tx_line_bit |=> (o_tx_level != $past(o_tx_level));
  endproperty
  a_mlt_change: assert property (p_mlt_change) else $error("one bit held the level");

  property p_mlt_hold;
    !tx_line_bit |=> $stable(o_tx_level);
  endproperty
  a_mlt_hold: assert property (p_mlt_hold) else $error("zero bit moved the level");

  property p_lock_hold;
    o_desc_locked |=> o_desc_locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("descrambler lost its lock");

  property p_rx_invalid;
    (in_frame && rx_cnt == `FEP_GRP_LAST && !rx_dec.data && !rx_dec.ctrl) |=> (o_rx_dv && o_rx_er);
  endproperty
  a_rx_invalid: assert property (p_rx_invalid) else $error("invalid group not flagged");

  property p_sof_std;
    (o_rx_sof && !frame_start_detect_strap) |-> (rx_sh == {`FEP_CG_J, `FEP_CG_K});
  endproperty
  a_sof_std: assert property (p_sof_std) else $error("frame start without J K");

endmodule // fep_line_coding

`default_nettype wire

// [pkg/fep_defs.svh]
`ifndef FEP_DEFS_SVH
`define FEP_DEFS_SVH

// Control code groups
`define FEP_CG_IDLE 5'h1F
`define FEP_CG_J 5'h18
`define FEP_CG_K 5'h11
`define FEP_CG_T 5'h0D
`define FEP_CG_R 5'h07
`define FEP_CG_H 5'h04

// Nibble presented for either start delimiter
`define FEP_NIB_JK 4'h5
// Bit index of the last bit of a code group
`define FEP_GRP_LAST 3'h4

// Key generator x^11 + x^9 + 1
`define FEP_LFSR_W 11
`define FEP_LFSR_TAP_A 10
`define FEP_LFSR_TAP_B 8
`define FEP_LFSR_RST 11'h7FF
// Low seed bits below the management address, kept nonzero
`define FEP_SEED_FILL 6'h2B
// Matching key bits in a row needed for descrambler lock
`define FEP_LOCK_RUN 6'h3C

// Strap default and capture point after reset release
`define FEP_STRAP_DEF 1'b1
`define FEP_STRAP_CAP 2'h2
`define FEP_STRAP_DONE 2'h3

// Three-level line codes
`define FEP_LVL_ZERO 2'h0
`define FEP_LVL_POS 2'h1
`define FEP_LVL_NEG 2'h3

`endif

// [pkg/fep_pkg.sv]
`include "fep_defs.svh"

package fep_pkg;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_J = 3'b001,
    TX_K = 3'b010,
    TX_DATA = 3'b011,
    TX_T = 3'b100,
    TX_R = 3'b101
  } fep_tx_st_e;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] nib;
  } fep_rx_s;

  typedef struct packed {
    logic data;
    logic ctrl;
    logic [3:0] nib;
  } fep_dec_s;

  function automatic logic [4:0] fep_enc(input logic [3:0] nib);
    logic [4:0] g;
    case (nib)
      4'h0: g = 5'h1E;
      4'h1: g = 5'h09;
      4'h2: g = 5'h14;
      4'h3: g = 5'h15;
      4'h4: g = 5'h0A;
      4'h5: g = 5'h0B;
      4'h6: g = 5'h0E;
      4'h7: g = 5'h0F;
      4'h8: g = 5'h12;
      4'h9: g = 5'h13;
      4'hA: g = 5'h16;
      4'hB: g = 5'h17;
      4'hC: g = 5'h1A;
      4'hD: g = 5'h1B;
      4'hE: g = 5'h1C;
      default: g = 5'h1D;
    endcase
    return g;
  endfunction

  function automatic fep_dec_s fep_dec(input logic [4:0] grp);
    fep_dec_s d;
    d = '0;
    for (int i = 0; i < 16; i++) begin
      if (fep_enc(4'(i)) == grp) begin
        d.data = 1'b1;
        d.nib = 4'(i);
      end
    end
    d.ctrl = (grp == `FEP_CG_IDLE) || (grp == `FEP_CG_J) || (grp == `FEP_CG_K) ||
             (grp == `FEP_CG_T) || (grp == `FEP_CG_R) || (grp == `FEP_CG_H);
    return d;
  endfunction

endpackage

// [rtl/fep_scr_lfsr.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fep_defs.svh"

module fep_scr_lfsr import fep_pkg::*; #(
  parameter int W = `FEP_LFSR_W
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_seed,
  input wire logic i_sync,
  input wire logic i_sync_bit,
  output logic o_key
);

  logic [W-1:0] state;
  logic [W-1:0] next_state;

  // Key bit of the current cycle from the two feedback taps
  assign o_key = state[`FEP_LFSR_TAP_A] ^ state[`FEP_LFSR_TAP_B];

  always_comb begin
    if (i_load) begin
      next_state = i_seed;
    end else if (i_sync) begin
      next_state = {state[W-2:0], i_sync_bit};
    end else begin
      next_state = {state[W-2:0], o_key};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= `FEP_LFSR_RST;
    end else begin
      state <= next_state;
    end
  end

endmodule // fep_scr_lfsr

`default_nettype wire

// [bench/fep_mac_model.sv]
`timescale 1ns/10ps
`default_nettype none

module fep_mac_model import fep_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_take,
  input wire logic i_start,
  input wire logic [4:0] i_err_idx,
  output logic o_tx_en,
  output logic o_tx_er,
  output logic [3:0] o_txd
);
  logic [4:0] idx;
  logic [4:0] nx;

  // Two preamble nibbles, then sixteen data nibbles equal to their index
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    nx = idx + 5'h01;
    if (!i_arst_n) begin
      o_tx_en <= 1'b0;
      o_tx_er <= 1'b0;
      o_txd <= 4'h0;
      idx <= 5'h00;
    end else if (i_start && !o_tx_en) begin
      o_tx_en <= 1'b1;
      o_tx_er <= 1'b0;
      o_txd <= 4'h5;
      idx <= 5'h00;
    end else if (i_take && o_tx_en) begin
      // Values change only at a take edge and stand until the next one
      idx <= nx;
      o_txd <= (nx < 5'h02) ? 4'h5 : nx[3:0] - 4'h2;
      o_tx_er <= (nx >= 5'h02) && (nx - 5'h02 == i_err_idx);
      o_tx_en <= nx < 5'h12;
    end
  end
endmodule // fep_mac_model

`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "fep_defs.svh"

module tb_top;
  logic i_sys_clk, i_arst_n, start, loop, strap, take, tx_en, tx_er, rx_dv, rx_er, rx_sof, locked, pb, kb;
  logic [4:0] phy_addr, err_idx;
  logic [3:0] txd, rxd;
  logic [1:0] gen_level, rx_level, tx_level, prev_lv, lastnz;
  logic [1:0] mst = 2'h0;
  logic [10:0] lf = 11'h155;
  logic bq[$];
  int err_total, check_count, tk_gap;
  logic [4:0] cg [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                          5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic [4:0] inv [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h19};

  assign rx_level = loop ? tx_level : gen_level;

  fep_line_coding uut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_tx_en(tx_en), .i_tx_er(tx_er),
    .i_txd(txd), .i_phy_addr(phy_addr), .i_frame_start_detect_strap(strap), .i_rx_level(rx_level),
    .o_tx_take(take), .o_tx_level(tx_level), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_rxd(rxd),
    .o_rx_sof(rx_sof), .o_desc_locked(locked));

  fep_mac_model mac (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_take(take), .i_start(start),
    .i_err_idx(err_idx), .o_tx_en(tx_en), .o_tx_er(tx_er), .o_txd(txd));

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // Far-end line source: scrambled, three-level, idle when nothing is queued
  always @(posedge i_sys_clk) begin
    pb = (bq.size() > 0) ? bq.pop_front() : 1'b1;
    kb = lf[10] ^ lf[8];
    lf = {lf[9:0], kb};
    if (pb ^ kb) mst = mst + 2'h1;
    gen_level <= mst[0] ? (mst[1] ? 2'h3 : 2'h1) : 2'h0;
  end

  task automatic summarize;
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  task automatic chk_rx(input logic [5:0] exp);
    check_count++;
    if ({rx_dv, rx_er, rxd} !== exp) begin
      err_total++;
      $display("Error at %0t: receive got %h expected %h", $time, {rx_dv, rx_er, rxd}, exp);
    end
  endtask

  // Three-level output: steps through zero only, peaks alternate
  always @(negedge i_sys_clk) begin
    if (i_arst_n !== 1'b1) begin
      prev_lv = 2'h0;
      lastnz = 2'h3;
      tk_gap = 0;
    end else begin
      tk_gap++;
      // Take pulse is one cycle wide, once every code group
      if (take === 1'b1 || tk_gap > 5) begin
        chk1(take === 1'b1 && tk_gap == 5, 1'b1, "take pulse spacing wrong");
        tk_gap = 0;
      end
      if (tx_level !== prev_lv) begin
        chk1(prev_lv == 2'h0 || tx_level == 2'h0, 1'b1, "level jumped between peaks");
        if (tx_level != 2'h0) begin
          chk1(tx_level != lastnz && tx_level != 2'h2, 1'b1, "peaks do not alternate");
          lastnz = tx_level;
        end
        prev_lv = tx_level;
      end
    end
  end

  task automatic reset_dut(input logic [4:0] addr, input logic s, input logic lp);
    @(posedge i_sys_clk);
    i_arst_n <= 1'b0;
    phy_addr <= addr;
    strap <= s;
    loop <= lp;
    bq.delete();
    repeat (8) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
  endtask

  task automatic push(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) bq.push_back(g[i]);
  endtask

  task automatic wait_lock;
    for (int i = 0; i < 2000 && locked !== 1'b1; i++) begin
      @(posedge i_sys_clk);
      #1;
    end
    chk1(locked, 1'b1, "descrambler never locked");
  endtask

  task automatic rx_expect(input logic [5:0] ex[$]);
    for (int i = 0; i < 3000 && rx_sof !== 1'b1; i++) begin
      @(posedge i_sys_clk);
      #1;
    end
    chk1(rx_sof, 1'b1, "no frame start seen");
    foreach (ex[k]) begin
      if (k > 0) begin
        repeat (5) @(posedge i_sys_clk);
        #1;
      end
      chk_rx(ex[k]);
    end
  endtask

  task automatic t_seed;
    logic [127:0] ra, rb;
    reset_dut(5'h01, 1'b0, 1'b0);
    repeat (20) @(posedge i_sys_clk);
    for (int i = 0; i < 64; i++) begin
      @(posedge i_sys_clk);
      #1 ra = {ra[125:0], tx_level};
    end
    reset_dut(5'h1E, 1'b0, 1'b0);
    repeat (20) @(posedge i_sys_clk);
    for (int i = 0; i < 64; i++) begin
      @(posedge i_sys_clk);
      #1 rb = {rb[125:0], tx_level};
    end
    chk1(ra !== rb, 1'b1, "same line sequence for two addresses");
  endtask

  task automatic t_tx_loop;
    logic [5:0] ex[$];
    reset_dut(5'h03, 1'b0, 1'b1);
    wait_lock();
    @(posedge i_sys_clk);
    start <= 1'b1;
    err_idx <= 5'h07;
    @(posedge i_sys_clk);
    start <= 1'b0;
    ex = '{6'h25};
    for (int i = 0; i < 16; i++) ex.push_back(i == 7 ? 6'h30 : {2'b10, 4'(i)});
    ex.push_back(6'h00);
    ex.push_back(6'h00);
    rx_expect(ex);
  endtask

  task automatic t_rx_strap0;
    logic [5:0] ex[$];
    reset_dut(5'h11, 1'b0, 1'b0);
    wait_lock();
    push(`FEP_CG_J);
    push(cg[3]);
    push(`FEP_CG_T);
    push(`FEP_CG_R);
    repeat (4) push(`FEP_CG_IDLE);
    push(`FEP_CG_J);
    push(`FEP_CG_K);
    ex = '{6'h25};
    for (int i = 0; i < 16; i++) begin
      push(cg[i]);
      ex.push_back({2'b10, 4'(i)});
    end
    push(`FEP_CG_H);
    ex.push_back(6'h30);
    foreach (inv[i]) begin
      push(inv[i]);
      ex.push_back(6'h30);
    end
    push(`FEP_CG_T);
    push(`FEP_CG_R);
    ex.push_back(6'h00);
    ex.push_back(6'h00);
    rx_expect(ex);
  endtask

  task automatic t_rx_strap1;
    reset_dut(5'h1F, 1'b1, 1'b0);
    wait_lock();
    push(`FEP_CG_J);
    push(`FEP_CG_K);
    push(cg[10]);
    push(`FEP_CG_T);
    push(`FEP_CG_R);
    rx_expect('{6'h25, 6'h25, 6'h2A, 6'h00});
  endtask

  initial begin
    i_arst_n = 1'b0;
    start = 1'b0;
    loop = 1'b0;
    strap = 1'b1;
    err_idx = 5'h00;
    phy_addr = 5'h00;
    gen_level = 2'h0;
    err_total = 0;
    check_count = 0;
    t_seed();
    t_tx_loop();
    t_rx_strap0();
    t_rx_strap1();
    summarize();
  end

  initial begin
    #400000;
    err_total++;
    summarize();
  end
endmodule // tb_top

`default_nettype wire
